// File: design/ee_pkg.sv
// Constants and types for the two-wire serial EEPROM target
package ee_pkg;

  localparam int PAGE_BYTES = 32;
  localparam int PAGE_OFF_W = 5;
  localparam int PAGES_SMALL = 128;
  localparam int PAGES_LARGE = 256;
  localparam int WORD_BITS = 8;
  localparam logic [3:0] BIT_CNT_FULL = 4'h8;
  localparam logic [3:0] DEVSEL_CODE = 4'hA;
  localparam logic [1:0] IDX_DEVSEL = 2'h0;
  localparam logic [1:0] IDX_ADDR_HI = 2'h1;
  localparam logic [1:0] IDX_ADDR_LO = 2'h2;
  localparam logic [1:0] IDX_DATA = 2'h3;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = PAGE_OFF_W + WORD_BITS;
  localparam logic LINE_IDLE = 1'b1;
  localparam int TMR_W = 20;

  // Write cycle: longest time, so the count rounds down
  localparam longint TWR_NS = 64'd5000000;
  localparam longint CLK_PERIOD_NS = 64'd8;
  localparam int TWR_CYCLES = int'(TWR_NS / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TXACK
  } ee_st_t;

endpackage : ee_pkg

// File: design/ee_strm_if.sv
// Valid/ready stream carrier between the target and its write FIFO
`timescale 1ns/1ns
`default_nettype none
interface ee_strm_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ee_strm_if
`default_nettype wire

// File: design/ee_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module ee_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] lvl_o
);
  import ee_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } ee_sync_st_t;

  ee_sync_st_t r, n;

  // Level moves only where stages two and three agree; stage one feeds two
  always_comb begin
    n = r;
    n.s1 = pin_i;
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < W; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        n.lvl[i] = r.s3[i];
      end
    end
  end

  // Idle bus lines are high, so reset there
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{default: {W{LINE_IDLE}}};
    end else begin
      r <= n;
    end
  end

  assign lvl_o = r.lvl;

endmodule : ee_sync
`default_nettype wire

// File: design/ee_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module ee_fifo #(
  parameter int W = 13,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  ee_strm_if.snk in_s,
  ee_strm_if.src out_s
);
  import ee_pkg::*;

  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("ee_fifo: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } ee_fifo_st_t;

  ee_fifo_st_t r, n;
  logic push;
  logic pop;

  // Full and empty come straight from the fill count
  assign in_s.ready = (r.cnt != (AW+1)'(DEPTH));
  assign out_s.valid = (r.cnt != '0);
  assign out_s.data = r.mem[r.rp];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = in_s.data;
      n.wp = r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = r.rp + 1'b1;
    end
    if (push && !pop) begin
      n.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      n.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

endmodule : ee_fifo
`default_nettype wire

// File: design/ee_target.sv
// Two-wire serial EEPROM target: bus protocol, array and write timer
`timescale 1ns/1ns
`default_nettype none
module ee_target #(
  parameter int PAGES = ee_pkg::PAGES_LARGE,
  parameter int TWR_CYCLES = ee_pkg::TWR_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic [2:0] chip_select_pins,
  output logic standby,
  output logic write_busy
);
  import ee_pkg::*;

  localparam int MEM_BYTES = PAGES * PAGE_BYTES;
  localparam int AW = $clog2(MEM_BYTES);
  localparam int PW = AW - PAGE_OFF_W;

  // Only the two documented array sizes are served
  generate
    if (PAGES != PAGES_SMALL && PAGES != PAGES_LARGE) begin : g_bad_pages
      $error("ee_target: PAGES must be 128 or 256");
    end
    if (TWR_CYCLES < 1 || TWR_CYCLES >= (1 << TMR_W)) begin : g_bad_twr
      $error("ee_target: TWR_CYCLES out of timer range");
    end
  endgenerate

  typedef struct packed {
    logic [MEM_BYTES-1:0][7:0] mem;
    logic [PAGE_BYTES-1:0][7:0] page_buf;
    logic [PAGE_BYTES-1:0] mask;
    logic [PW-1:0] page;
    logic [AW-1:0] ptr;
    ee_st_t st;
    logic [3:0] cnt;
    logic [1:0] idx;
    logic [7:0] sh;
    logic [7:0] hi;
    logic rd;
    logic acked;
    logic push_v;
    logic [FIFO_W-1:0] push_d;
    logic wr_pend;
    logic commit;
    logic busy;
    logic [TMR_W-1:0] tmr;
    logic scl_p;
    logic sda_p;
    logic sda_o;
    logic sda_oe_n;
    logic standby;
  } ee_tgt_st_t;

  ee_tgt_st_t r, n;

  logic [4:0] lvl;
  logic scl_s;
  logic sda_s;
  logic [2:0] cs_s;
  logic start_ev;
  logic stop_ev;
  logic rise_ev;
  logic fall_ev;
  logic load_rd;

  ee_strm_if #(.W(FIFO_W)) wr_in ();
  ee_strm_if #(.W(FIFO_W)) wr_out ();

  // Select word check: fixed code on top, pins in the middle
  function automatic logic devsel_match(input logic [7:0] w,
                                        input logic [2:0] cs);
    devsel_match = (w[7:4] == DEVSEL_CODE) && (w[3:1] == cs);
  endfunction : devsel_match

  // Pins and straps cross into the clock domain here
  ee_sync #(.W(5)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .pin_i({chip_select_pins, scl_i, sda_i}),
    .lvl_o(lvl)
  );

  assign cs_s = lvl[4:2];
  assign scl_s = lvl[1];
  assign sda_s = lvl[0];

  // Received write bytes queue here before landing in the page latch
  ee_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_s(wr_in),
    .out_s(wr_out)
  );

  assign wr_in.valid = r.push_v;
  assign wr_in.data = r.push_d;
  // Latch is frozen while it is being committed and timed
  assign wr_out.ready = !r.busy && !r.commit;

  // Bus events from the filtered, registered levels
  assign start_ev = r.scl_p && scl_s && r.sda_p && !sda_s;
  assign stop_ev = r.scl_p && scl_s && !r.sda_p && sda_s;
  assign rise_ev = !r.scl_p && scl_s;
  assign fall_ev = r.scl_p && !scl_s;

  always_comb begin
    n = r;
    load_rd = 1'b0;
    n.scl_p = scl_s;
    n.sda_p = sda_s;

    // Push strobe drops once the FIFO took the word
    if (r.push_v && wr_in.ready) begin
      n.push_v = 1'b0;
    end

    // Drain queued bytes into the page latch
    if (wr_out.valid && wr_out.ready) begin
      n.page_buf[wr_out.data[FIFO_W-1:WORD_BITS]] =
        wr_out.data[WORD_BITS-1:0];
      n.mask[wr_out.data[FIFO_W-1:WORD_BITS]] = 1'b1;
    end

    // Self-timed write cycle countdown
    if (r.busy) begin
      if (r.tmr == '0) begin
        n.busy = 1'b0;
      end else begin
        n.tmr = r.tmr - 1'b1;
      end
    end

    // Commit waits for the queue to empty so no byte is left behind
    if (r.commit && !wr_out.valid && !r.push_v) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (r.mask[i]) begin
          n.mem[{r.page, PAGE_OFF_W'(i)}] = r.page_buf[i];
        end
      end
      n.mask = '0;
      n.commit = 1'b0;
      n.busy = 1'b1;
      n.tmr = TMR_W'(TWR_CYCLES - 1);
    end

    // Framing beats bit handling: data moving under a high clock is framing
    if (start_ev) begin
      n.st = ST_RX;
      n.cnt = '0;
      n.idx = IDX_DEVSEL;
      n.rd = 1'b0;
      n.wr_pend = 1'b0;
      n.sda_oe_n = 1'b1;
    end else if (stop_ev) begin
      n.st = ST_IDLE;
      n.sda_oe_n = 1'b1;
      if (r.wr_pend) begin
        n.commit = 1'b1;
        n.wr_pend = 1'b0;
      end
    end else begin
      case (r.st)
        ST_IDLE: begin
          n.sda_oe_n = 1'b1;
        end
        ST_RX: begin
          if (rise_ev && r.cnt != BIT_CNT_FULL) begin
            n.sh = {r.sh[6:0], sda_s};
            n.cnt = r.cnt + 1'b1;
          end else if (fall_ev && r.cnt == BIT_CNT_FULL) begin
            n.st = ST_ACK;
            case (r.idx)
              IDX_DEVSEL: begin
                if (devsel_match(r.sh, cs_s) && !r.busy && !r.commit) begin
                  n.rd = r.sh[0];
                end else begin
                  n.st = ST_IDLE;
                end
              end
              IDX_ADDR_HI: begin
                n.hi = r.sh;
              end
              IDX_ADDR_LO: begin
                n.ptr = AW'({r.hi, r.sh});
                // Page row is the address above the in-page offset
                n.page = PW'(AW'({r.hi, r.sh}) >> PAGE_OFF_W);
                n.mask = '0;
              end
              default: begin
                // A full queue refuses the byte instead of losing it
                if (wr_in.ready && !r.push_v) begin
                  n.push_v = 1'b1;
                  n.push_d = {r.ptr[PAGE_OFF_W-1:0], r.sh};
                  n.ptr[PAGE_OFF_W-1:0] =
                    r.ptr[PAGE_OFF_W-1:0] + 1'b1;
                  n.wr_pend = 1'b1;
                end else begin
                  n.st = ST_IDLE;
                end
              end
            endcase
            if (n.st == ST_ACK) begin
              n.sda_oe_n = 1'b0;
              if (r.idx != IDX_DATA) begin
                n.idx = r.idx + 1'b1;
              end
            end
          end
        end
        ST_ACK: begin
          // Ninth clock ends on its falling edge
          if (fall_ev) begin
            n.cnt = '0;
            if (r.rd) begin
              load_rd = 1'b1;
            end else begin
              n.sda_oe_n = 1'b1;
              n.st = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (rise_ev) begin
            n.cnt = r.cnt + 1'b1;
          end else if (fall_ev) begin
            if (r.cnt == BIT_CNT_FULL) begin
              n.sda_oe_n = 1'b1;
              n.st = ST_TXACK;
            end else begin
              n.sh = {r.sh[6:0], 1'b0};
              n.sda_oe_n = r.sh[6];
            end
          end
        end
        ST_TXACK: begin
          if (rise_ev) begin
            n.acked = !sda_s;
          end else if (fall_ev) begin
            n.cnt = '0;
            if (r.acked) begin
              load_rd = 1'b1;
            end else begin
              n.st = ST_IDLE;
            end
          end
        end
        default: begin
          n.st = ST_IDLE;
        end
      endcase
    end

    // Next read byte; address wraps over the whole array on reads
    if (load_rd) begin
      n.sh = r.mem[r.ptr];
      n.ptr = r.ptr + 1'b1;
      n.sda_oe_n = r.mem[r.ptr][7];
      n.st = ST_TX;
    end

    n.sda_o = 1'b0;
    n.standby = (n.st == ST_IDLE) && !n.busy && !n.commit;
  end

  // Power-on reset puts the target in standby with the line released
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.scl_p <= LINE_IDLE;
      r.sda_p <= LINE_IDLE;
      r.sda_oe_n <= 1'b1;
      r.standby <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign sda_o = r.sda_o;
  assign sda_oe_n = r.sda_oe_n;
  assign standby = r.standby;
  assign write_busy = r.busy;

endmodule : ee_target
`default_nettype wire

// File: bench/ee_target_checker.sv
// Port-level protocol checker for the EEPROM target
`timescale 1ns/1ns
`default_nettype none
module ee_target_checker #(
  parameter int TWR_CYCLES = 20
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic standby,
  input wire logic write_busy
);
  int bcnt_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Busy run length; a repetition this long would unroll badly
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bcnt_q <= 0;
    end else begin
      bcnt_q <= write_busy ? bcnt_q + 1 : 0;
    end
  end
  a_reset_idle_out: assert property (
    $rose(arst_n) |-> sda_oe_n && standby && !write_busy)
    else $error("outputs not idle after reset");
  a_drive_low_only: assert property (
    !sda_oe_n |-> sda_o == 1'b0) else $error("data driven high");
  a_hold_clock_high: assert property (
    $rose(scl_i) && !sda_oe_n |-> !sda_oe_n [*8])
    else $error("drive dropped while clock high");
  a_change_clock_low: assert property (
    $changed(sda_oe_n) |-> !scl_i) else $error("drive moved, clock high");
  a_busy_not_standby: assert property (
    write_busy |-> !standby) else $error("standby during write");
  a_busy_released: assert property (
    write_busy |-> sda_oe_n) else $error("answer during write");
  a_standby_released: assert property (
    standby |-> sda_oe_n) else $error("drive in standby");
  a_busy_exact_len: assert property (
    $fell(write_busy) |-> bcnt_q == TWR_CYCLES)
    else $error("write cycle length wrong");
  a_busy_bounded: assert property (
    bcnt_q <= TWR_CYCLES) else $error("write cycle too long");
  a_start_wakes: assert property (
    scl_i && $fell(sda_i) && standby |-> ##[1:10] !standby)
    else $error("start not seen");
endmodule : ee_target_checker
bind ee_target ee_target_checker #(.TWR_CYCLES(TWR_CYCLES)) u_chk (
  .clk(clk), .arst_n(arst_n), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_n(sda_oe_n), .standby(standby),
  .write_busy(write_busy)
);
`default_nettype wire

// File: bench/ee_master_model.sv
// Behavioural two-wire bus master; clock stands high between frames
`timescale 1ns/1ns
`default_nettype none
module ee_master_model (
  input wire logic sda_w,
  output logic scl,
  output logic sda_m,
  output logic [7:0] res_v,
  output logic res_t
);
  localparam int Q = 40;
  int lowx = 0;
  logic r;
  // Idle bus: both lines released high
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
    res_v = 8'h00;
    res_t = 1'b0;
  end
  // One clock; lowx stretches the low phase for a slow master
  task automatic clk_bit(input logic b, output logic s);
    sda_m = b;
    #(Q + lowx);
    scl = 1'b1;
    #Q;
    s = sda_w;
    #Q;
    scl = 1'b0;
    #Q;
  endtask : clk_bit
  task automatic start();
    sda_m = 1'b1;
    #Q;
    scl = 1'b1;
    #Q;
    sda_m = 1'b0;
    #Q;
    scl = 1'b0;
    #Q;
  endtask : start
  task automatic stop();
    sda_m = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sda_m = 1'b1;
    #Q;
  endtask : stop
  // Whole words, top bit first; the ninth clock carries the answer
  task automatic wr_byte(input logic [7:0] b);
    int i;
    for (i = 7; i >= 0; i--) clk_bit(b[i], r);
    clk_bit(1'b1, r);
    res_v = {7'h00, r};
    #1 res_t = ~res_t;
  endtask : wr_byte
  task automatic rd_byte(input logic ma);
    int i;
    logic [7:0] v;
    for (i = 7; i >= 0; i--) begin
      clk_bit(1'b1, r);
      v[i] = r;
    end
    clk_bit(ma, r);
    res_v = v;
    #1 res_t = ~res_t;
  endtask : rd_byte
endmodule : ee_master_model
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench: EEPROM target against a bus master model
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import ee_pkg::*;
  localparam int SELF_TIMED_WRITE_DURATION = 400;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] cs_pins = 3'h0;
  wire scl, sda_m, sda_w, res_t, sda_o, sda_oe_n, standby, write_busy;
  wire [7:0] res_v;
  int bad_count = 0;
  int compares = 0;
  logic [16:0] lfsr_q = 17'h11D36;
  logic [7:0] mem [int];
  logic [8:0] expq [$];
  logic [8:0] exp_v;
  logic rv;
  always #4 clk = ~clk;
  // Open-drain data wire with pull-up
  assign sda_w = sda_m & (sda_oe_n | sda_o);
  ee_target #(.PAGES(PAGES_LARGE), .TWR_CYCLES(SELF_TIMED_WRITE_DURATION)) uut (
    .clk(clk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .chip_select_pins(cs_pins),
    .standby(standby), .write_busy(write_busy));
  ee_master_model m (.sda_w(sda_w), .scl(scl), .sda_m(sda_m),
    .res_v(res_v), .res_t(res_t));
  task automatic chk_bit(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s exp %b got %b", n, e, g);
    end
  endtask : chk_bit
  task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch read_data exp %h got %h", e, g);
    end
  endtask : chk_byte
  // Oldest note against each result the master reports
  always @(res_t) begin
    if ($time > 0) begin
      exp_v = expq.pop_front();
      if (exp_v[8]) chk_byte(exp_v[7:0], res_v);
      else chk_bit("ack", exp_v[0], res_v[0]);
    end
  end
  task automatic wb(input logic [7:0] b, input logic ea);
    expq.push_back({1'b0, 7'h00, ea});
    m.wr_byte(b);
  endtask : wb
  task automatic rd_at(input logic [7:0] hi, lo, input int a, c);
    int i;
    m.start();
    wb({4'hA, cs_pins, 1'b0}, 1'b0);
    wb(hi, 1'b0);
    wb(lo, 1'b0);
    m.start();
    wb({4'hA, cs_pins, 1'b1}, 1'b0);
    for (i = 0; i < c; i++) begin
      expq.push_back({1'b1, mem[a + i]});
      m.rd_byte(i == c - 1);
    end
    m.stop();
    repeat (20) @(negedge clk);
    chk_bit("standby", 1'b1, standby);
  endtask : rd_at
  task automatic stop_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    int n;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    lfsr_q = {lfsr_q[15:0], lfsr_q[16] ^ lfsr_q[13]};
    cs_pins = lfsr_q[2:0];
    repeat (6) @(negedge clk);
    chk_bit("standby", 1'b1, standby);
    wb({4'hA, cs_pins, 1'b0}, 1'b1);
    m.stop();
    // Page write that wraps at the page end, upper bits don't-care
    m.start();
    wb({4'hA, cs_pins, 1'b0}, 1'b0);
    wb(8'hFF, 1'b0);
    wb(8'hFE, 1'b0);
    for (n = 0; n < 3; n++) begin
      lfsr_q = {lfsr_q[15:0], lfsr_q[16] ^ lfsr_q[13]};
      mem[n == 2 ? 32'h1FE0 : 32'h1FFE + n] = lfsr_q[7:0];
      wb(lfsr_q[7:0], 1'b0);
    end
    m.stop();
    for (n = 0; n < 60 && write_busy !== 1'b1; n++) @(negedge clk);
    chk_bit("standby", 1'b0, standby);
    m.start();
    wb({4'hA, cs_pins, 1'b0}, 1'b1);
    m.stop();
    for (n = 0; n < SELF_TIMED_WRITE_DURATION && write_busy === 1'b1; n++) @(negedge clk);
    chk_bit("write_busy", 1'b0, write_busy);
    m.start();
    wb({4'hA, cs_pins, 1'b0}, 1'b0);
    m.stop();
    rd_at(8'h1F, 8'hFE, 32'h1FFE, 2);
    m.lowx = 200;
    rd_at(8'h3F, 8'hE0, 32'h1FE0, 1);
    m.lowx = 0;
    // Foreign select, then a read cut short and recovered
    m.start();
    wb({4'hA, cs_pins ^ 3'h5, 1'b0}, 1'b1);
    wb(8'h00, 1'b1);
    m.stop();
    m.start();
    wb({4'hA, cs_pins, 1'b1}, 1'b0);
    m.start();
    for (n = 0; n < 9; n++) m.clk_bit(1'b1, rv);
    m.start();
    m.stop();
    rd_at(8'h1F, 8'hFF, 32'h1FFF, 1);
    stop_test();
  end
  // Cuts a hang short; the sequence needs well under 200 us
  initial begin
    #400000;
    bad_count++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire
